/* rtl/cof_framer.sv */
// Conversion and register read-out framer with counter and integrity trailer
`timescale 1ns/1ps
// Contract
// - Temperature mode ignores routing and gain, forces internal reference.
// - Temperature results use the same start and read path as inputs.
// - Temperature 14-bit result is left-justified in the 16-bit word.
// - Two lowest temperature bits carry nothing; host discards them.
// - Serial output of each byte goes least significant bit first.
// - One temperature step is 0.03125 C, negatives in two's complement.
// - Codes 0FFF max, 0001 one step, 3FF8 -0.25 C, 3B00 -40 C.
// - With counter enabled, an 8-bit counter precedes each conversion read.
// - Counter starts at 00h, increments per conversion, wraps FFh to 00h.
// - Counter clears when enable goes 0 then 1, and on reset.
// - Integrity protection covers register read-outs and conversion results.
// - Enabled counter byte is covered by the integrity protection.
// - Mode 01 sends inverted data copy right after the last data byte.
// - Mode 10 sends a 16-bit checksum right after the last data byte.
// - Checksum is CRC-16 poly 1021h, preset FFFFh.
module cof_framer
	import cof_pkg::*;
#(
	parameter int DATA_BYTES = 2
)(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Configuration
	input wire logic [3:0] cfg_input_route,
	input wire logic [2:0] cfg_gain,
	input wire logic [1:0] cfg_ref_select,
	input wire cof_cfg_t cfg,
	// Converter side
	input wire logic conv_done,
	input wire logic [15:0] conv_raw,
	input wire logic [15:0] temp_raw,
	// Read requests
	input wire logic read_conv,
	input wire logic read_reg,
	input wire logic [7:0] reg_data,
	// Serial output
	input wire logic tx_tick,
	// Outputs
	output logic [3:0] ana_input_route,
	output logic [2:0] ana_gain,
	output logic [1:0] ana_ref_select,
	output logic tx,
	output logic busy,
	output logic [7:0] conv_count
);

	// ==========================================================
	// Parameter check
	initial begin
		if (DATA_BYTES != 2) begin
			$error("DATA_BYTES must be 2");
		end
	end

	localparam logic [1:0] ROUTE_INT_REF = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_START,
		ST_BITS,
		ST_STOP
	} cof_state_t;

	// ==========================================================
	// Analog routing overrides
	wire logic [3:0] next_route = cfg.temp_sensor_select ? 4'h0 : cfg_input_route;
	wire logic [2:0] next_gain = cfg.temp_sensor_select ? 3'h0 : cfg_gain;
	wire logic [1:0] next_ref = cfg.temp_sensor_select ? ROUTE_INT_REF : cfg_ref_select;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ana_input_route <= 4'h0;
			ana_gain <= 3'h0;
			ana_ref_select <= 2'h0;
		end else begin
			ana_input_route <= next_route;
			ana_gain <= next_gain;
			ana_ref_select <= next_ref;
		end
	end

	// ==========================================================
	// Result latch: same path for temperature and inputs
	// Temperature core gives 14 bits; pad two zero LSBs
	wire logic [15:0] temp_word = {temp_raw[COF_TEMP_BITS-1:0], {COF_TEMP_PAD{1'b0}}};
	wire logic [15:0] next_result = cfg.temp_sensor_select ? temp_word : conv_raw;
	logic [15:0] result;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			result <= 16'h0000;
		end else if (conv_done) begin
			result <= next_result;
		end
	end

	// ==========================================================
	// Conversion counter
	logic cnt_en_q;
	wire logic cnt_rearm = cfg.conv_counter_enable & ~cnt_en_q;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			conv_count <= COF_CNT_RESET;
			cnt_en_q <= 1'b0;
		end else begin
			cnt_en_q <= cfg.conv_counter_enable;
			if (cnt_rearm) begin
				conv_count <= COF_CNT_RESET;
			end else if (conv_done) begin
				conv_count <= conv_count + 8'h01;
			end
		end
	end

	// ==========================================================
	// Frame assembly: up to 6 bytes
	// Frame shape is frozen at request so config changes mid-frame are harmless
	logic [7:0] frame [0:5];
	logic [2:0] frame_len;
	logic [2:0] byte_idx;
	logic [2:0] bit_idx;
	logic [7:0] shreg;
	logic [1:0] mode_q;
	logic [15:0] crc;
	cof_state_t state;

	wire logic start_conv = (state == ST_IDLE) && read_conv;
	wire logic start_reg = (state == ST_IDLE) && read_reg && !read_conv;
	wire logic with_cnt = start_conv && cfg.conv_counter_enable;
	wire logic [7:0] b0 = start_reg ? reg_data : (with_cnt ? conv_count : result[7:0]);
	wire logic [7:0] b1 = with_cnt ? result[7:0] : result[15:8];
	wire logic [7:0] b2 = result[15:8];
	wire logic [2:0] data_len = start_reg ? 3'h1 : (with_cnt ? 3'h3 : 3'h2);
	// Inverted copy of the data section, just after the last data byte
	wire logic [7:0] inv_lo = start_reg ? ~reg_data : ~b0;
	wire logic [7:0] inv_mid = ~b1;
	wire logic [7:0] inv_hi = ~b2;

	// CRC accumulated byte by byte as bytes leave the shifter
	wire logic [15:0] crc_next;
	cof_crc_step u_crc (
		.crc_in(crc),
		.data_in(shreg),
		.crc_out(crc_next)
	);

	logic [2:0] data_len_q;
	wire logic in_data = byte_idx < data_len_q;
	wire logic [2:0] next_byte = byte_idx + 3'h1;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			tx <= 1'b1;
			busy <= 1'b0;
			frame_len <= 3'h0;
			data_len_q <= 3'h0;
			byte_idx <= 3'h0;
			bit_idx <= 3'h0;
			shreg <= 8'h00;
			mode_q <= COF_INTEG_NONE;
			crc <= COF_CRC_INIT;
			for (int i = 0; i < 6; i++) begin
				frame[i] <= 8'h00;
			end
		end else begin
			case (state)
				ST_IDLE: begin
					tx <= 1'b1;
					if (start_conv || start_reg) begin
						busy <= 1'b1;
						mode_q <= cfg.integ_mode;
						data_len_q <= data_len;
						frame[0] <= b0;
						frame[1] <= start_reg ? inv_lo : b1;
						frame[2] <= b2;
						frame[3] <= inv_mid;
						frame[4] <= inv_hi;
						frame[5] <= inv_hi;
						if (cfg.integ_mode == COF_INTEG_INV) begin
							// Inverted copy covers counter and data alike
							frame_len <= data_len + data_len;
							if (!start_reg) begin
								if (with_cnt) begin
									frame[3] <= inv_lo;
									frame[4] <= inv_mid;
									frame[5] <= inv_hi;
								end else begin
									frame[2] <= inv_lo;
									frame[3] <= inv_mid;
								end
							end
						end else if (cfg.integ_mode == COF_INTEG_CRC) begin
							frame_len <= data_len + 3'h2;
						end else begin
							frame_len <= data_len;
						end
						crc <= COF_CRC_INIT;
						byte_idx <= 3'h0;
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					shreg <= frame[byte_idx];
					if (!in_data && mode_q == COF_INTEG_CRC) begin
						// CRC high byte first, then low byte
						shreg <= (byte_idx == data_len_q) ? crc[15:8] : crc[7:0];
					end
					state <= ST_START;
				end
				ST_START: begin
					if (tx_tick) begin
						tx <= 1'b0;
						bit_idx <= 3'h0;
						state <= ST_BITS;
					end
				end
				ST_BITS: begin
					if (tx_tick) begin
						tx <= shreg[bit_idx];
						bit_idx <= bit_idx + 3'h1;
						if (bit_idx == 3'h7) begin
							state <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (tx_tick) begin
						tx <= 1'b1;
						if (in_data) begin
							crc <= crc_next;
						end
						if (next_byte == frame_len) begin
							busy <= 1'b0;
							state <= ST_IDLE;
						end else begin
							byte_idx <= next_byte;
							state <= ST_LOAD;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule : cof_framer

/* rtl/cof_pkg.sv */
// Package of constants and carrier types for the conversion output framer
package cof_pkg;

	// ==========================================================
	// Integrity modes
	localparam logic [1:0] COF_INTEG_NONE = 2'h0;
	localparam logic [1:0] COF_INTEG_INV = 2'h1;
	localparam logic [1:0] COF_INTEG_CRC = 2'h2;

	// ==========================================================
	// Checksum
	localparam logic [15:0] COF_CRC_POLY = 16'h1021;
	localparam logic [15:0] COF_CRC_INIT = 16'hffff;

	// ==========================================================
	// Counter and temperature format
	localparam logic [7:0] COF_CNT_RESET = 8'h00;
	localparam int COF_TEMP_BITS = 14;
	localparam int COF_TEMP_PAD = 2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic temp_sensor_select;
		logic conv_counter_enable;
		logic [1:0] integ_mode;
	} cof_cfg_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cof_byte_t;

endpackage : cof_pkg

/* rtl/cof_crc_step.sv */
// One-byte CRC-16 update, most significant bit first
`timescale 1ns/1ps
module cof_crc_step
	import cof_pkg::*;
(
	// Inputs
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data_in,
	// Output
	output logic [15:0] crc_out
);

	// ==========================================================
	// Bitwise division, eight steps unrolled by loop
	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ data_in[i]) begin
				c = {c[14:0], 1'b0} ^ COF_CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_out = c;
	end

endmodule : cof_crc_step

/* testbench/cof_framer_chk.sv */
// Port checker for the framer
`timescale 1ns/1ps
module cof_framer_chk
	import cof_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Inputs
	input wire logic [3:0] cfg_input_route,
	input wire cof_cfg_t cfg,
	input wire logic conv_done,
	input wire logic read_conv,
	input wire logic read_reg,
	input wire logic tx_tick,
	// Outputs
	input wire logic [3:0] ana_input_route,
	input wire logic [2:0] ana_gain,
	input wire logic [1:0] ana_ref_select,
	input wire logic tx,
	input wire logic busy,
	input wire logic [7:0] conv_count
);
	// ==========================================================
	// Relations
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_temp; cfg.temp_sensor_select |=> {ana_input_route, ana_gain, ana_ref_select} == 9'h0; endproperty
	a_temp: assert property (p_temp) else $error("route not zero");
	property p_route; !cfg.temp_sensor_select |=> ana_input_route == $past(cfg_input_route); endproperty
	a_route: assert property (p_route) else $error("route lost");
	property p_inc; conv_done && cfg.conv_counter_enable && $past(cfg.conv_counter_enable) |=> conv_count == $past(conv_count) + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("count step");
	property p_hold; !conv_done && !$rose(cfg.conv_counter_enable) |=> $stable(conv_count); endproperty
	a_hold: assert property (p_hold) else $error("count moved");
	property p_rearm; $rose(cfg.conv_counter_enable) |=> conv_count == 8'h00; endproperty
	a_rearm: assert property (p_rearm) else $error("count not cleared");
	property p_take; !busy && (read_conv || read_reg) |=> busy; endproperty
	a_take: assert property (p_take) else $error("request lost");
	property p_tick; !$past(tx_tick) |-> $stable(tx); endproperty
	a_tick: assert property (p_tick) else $error("bit off tick");
	property p_idle; !busy && !$past(busy) |-> tx; endproperty
	a_idle: assert property (p_idle) else $error("line not idle");
	property p_start; $fell(tx) |-> busy; endproperty
	a_start: assert property (p_start) else $error("start out of frame");
endmodule : cof_framer_chk

/* testbench/cof_host.sv */
// Host receiver model on the serial line
`timescale 1ns/1ps
module cof_host (
	// Line
	input wire logic clock,
	input wire logic tx,
	input wire logic tx_tick
);
	int st = 0;
	logic [7:0] sh = 8'h00;
	logic [7:0] q[$];
	// A missing stop bit drops the byte, so the count check catches it
	always @(posedge clock) begin
		if (tx_tick) begin
			if (st == 0) begin
				st <= !tx;
			end else if (st < 9) begin
				sh <= {tx, sh[7:1]};
				st <= st + 1;
			end else begin
				if (tx) q.push_back(sh);
				st <= 0;
			end
		end
	end
endmodule : cof_host

/* testbench/tb_top.sv */
// Testbench for the framer
`timescale 1ns/1ps
module tb_top import cof_pkg::*;;
	logic clock = 0, sys_rst = 1, conv_done = 0, read_conv = 0, read_reg = 0, tx_tick = 0;
	logic [3:0] cfg_input_route = 4'h5, ana_input_route;
	logic [2:0] cfg_gain = 3'h6, ana_gain;
	logic [1:0] cfg_ref_select = 2'h1, ana_ref_select;
	logic [15:0] conv_raw = 16'ha55a, temp_raw = 16'h0000;
	logic [7:0] reg_data = 8'h00, conv_count;
	logic tx, busy;
	cof_cfg_t cfg = '0;
	int err_count = 0, num_checks = 0, t = 0;
	logic [7:0] e[$];
	always #2.5 clock = ~clock;
	always @(negedge clock) begin
		t = t + 1;
		tx_tick <= (t % 4 == 0);
	end
	cof_framer dut (.clock, .sys_rst, .cfg_input_route, .cfg_gain, .cfg_ref_select, .cfg,
		.conv_done, .conv_raw, .temp_raw, .read_conv, .read_reg, .reg_data, .tx_tick,
		.ana_input_route, .ana_gain, .ana_ref_select, .tx, .busy, .conv_count);
	cof_host host (.clock, .tx, .tx_tick);
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic pulse(input int k);
		repeat (k) begin
			conv_done = 1;
			@(negedge clock);
			conv_done = 0;
			@(negedge clock);
		end
	endtask : pulse
	// Expected data bytes are built in e before the call
	task automatic run(input logic rc, input logic [1:0] m);
		int n = 0;
		logic [7:0] d[$];
		logic [15:0] c = COF_CRC_INIT;
		d = e;
		foreach (d[i]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][k]) ? COF_CRC_POLY : 16'h0);
		if (m == 2'h1) foreach (d[i]) e.push_back(~d[i]);
		if (m == 2'h2) e = {e, c[15:8], c[7:0]};
		cfg.integ_mode = m;
		host.q = {};
		read_conv = rc;
		read_reg = !rc;
		@(negedge clock);
		read_conv = 0;
		read_reg = 0;
		while (busy !== 1'b0 && n < 4000) @(negedge clock) n++;
		if (n >= 4000) err_count++;
		repeat (8) @(negedge clock);
		chk(16'(host.q.size()), 16'(e.size()));
		foreach (e[i]) chk(host.q[i], e[i]);
		if (m == 2'h2 && host.q.size() == e.size()) begin
			c = COF_CRC_INIT;
			for (int i = 0; i < host.q.size() - 2; i++) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ host.q[i][k]) ? COF_CRC_POLY : 16'h0);
			chk({host.q[e.size() - 2], host.q[e.size() - 1]}, c);
		end
	endtask : run
	// ==========================================================
	// Scenarios
	task automatic t_conv();
		cfg = '{1'b0, 1'b1, 2'h0};
		@(negedge clock);
		pulse(3);
		chk({ana_input_route, ana_gain, ana_ref_select}, 16'h0b9);
		for (int m = 0; m < 4; m++) begin
			e = {8'h03, 8'h5a, 8'ha5};
			run(1, m[1:0]);
			chk(host.q[0], 16'h03);
		end
	endtask : t_conv
	task automatic t_temp();
		logic [13:0] tc[4] = '{14'h0fff, 14'h0001, 14'h3ff8, 14'h3b00};
		logic [15:0] w;
		logic [13:0] v;
		int mag[4] = '{4095, 1, 8, 1280};
		cfg = '{1'b1, 1'b0, 2'h0};
		foreach (tc[i]) begin
			temp_raw = {2'h2, tc[i]};
			pulse(1);
			chk({ana_input_route, ana_gain, ana_ref_select}, 16'h0);
			w = {tc[i], 2'h0};
			e = {w[7:0], w[15:8]};
			run(1, 2'h1);
			v = 14'({host.q[1], host.q[0]} >> 2);
			chk(16'(v), 16'(tc[i]));
			if (v[13]) v = ~(v - 14'h1);
			chk(16'(v), 16'(mag[i]));
		end
	endtask : t_temp
	task automatic t_reg();
		cfg = '{1'b0, 1'b1, 2'h0};
		reg_data = 8'hc3;
		for (int m = 0; m < 4; m++) begin
			e = {8'hc3};
			run(0, m[1:0]);
		end
	endtask : t_reg
	task automatic t_wrap();
		pulse(255);
		chk(conv_count, 16'hff);
		pulse(1);
		chk(conv_count, 16'h00);
		pulse(5);
		cfg.conv_counter_enable = 0;
		@(negedge clock);
		cfg.conv_counter_enable = 1;
		repeat (2) @(negedge clock);
		chk(conv_count, 16'h00);
		pulse(2);
		sys_rst = 1;
		@(negedge clock);
		sys_rst = 0;
		chk(conv_count, 16'h00);
	endtask : t_wrap
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (16) @(negedge clock);
		sys_rst = 0;
		t_conv();
		t_temp();
		t_reg();
		t_wrap();
		summarize();
	end
	// Run is about 2300 cycles; allow about 35 times that
	initial begin
		#400000;
		err_count++;
		summarize();
	end
endmodule : tb_top
bind cof_framer cof_framer_chk chk (.clock, .sys_rst, .cfg_input_route, .cfg, .conv_done,
	.read_conv, .read_reg, .tx_tick, .ana_input_route, .ana_gain, .ana_ref_select, .tx,
	.busy, .conv_count);
